/* hw/fss_pkg.sv */
// Shared constants, types and helpers for the flash status register block.
package fss_pkg;

  // ****************************************************************
  // Command codes seen on the serial link
  // ****************************************************************
  localparam logic [7:0] OP_WRITE_ENABLE_COMMAND  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_READ_STATUS_COMMAND  = 8'h05;
  localparam logic [7:0] OP_READ_STATUS3_COMMAND = 8'h95;
  localparam logic [7:0] OP_STATUS_WRITE_COMMAND  = 8'h01;
  localparam logic [7:0] OP_WRSR3 = 8'hC0;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_HBE   = 8'h52;
  localparam logic [7:0] OP_BE    = 8'hD8;
  localparam logic [7:0] OP_CE1   = 8'hC7;
  localparam logic [7:0] OP_CE2   = 8'h60;

  // ****************************************************************
  // Field positions in the status bytes
  // ****************************************************************
  localparam int SB_WIP   = 0;
  localparam int SB_WEL   = 1;
  localparam int SB_BP_LO = 2;
  localparam int SB_BP_HI = 5;
  localparam int SB_TB    = 3;
  localparam int SB_SIZE  = 4;
  localparam int SB_EBL   = 6;
  localparam int SB_PPB   = 7;
  localparam int SB_OTPL  = 7;
  localparam int CB_DRV_LO = 2;
  localparam int CB_DRV_HI = 3;
  localparam int CB_DUM_LO = 4;
  localparam int CB_DUM_HI = 5;

  // Protection vector: PERMANENT_PROTECT_BIT, BOOT_LOCK_ENABLE, BP[3:0], OTP lock, TB, size switch.
  localparam int PV_SIZE  = 0;
  localparam int PV_TB    = 1;
  localparam int PV_OTPL  = 2;
  localparam int PV_BP_LO = 3;
  localparam int PV_BP_HI = 6;
  localparam int PV_EBL   = 7;
  localparam int PV_PPB   = 8;

  // ****************************************************************
  // Reset values, bit counts and timing
  // ****************************************************************
  localparam logic [8:0] PV_RST   = 9'h000;
  localparam logic [7:0] CB_RST   = 8'h00;
  localparam logic [7:0] CB_WMASK = 8'h3C;
  localparam logic [5:0] N_CMD    = 6'h08;
  localparam logic [5:0] N_STATUS_WRITE_COMMAND   = 6'h10;
  localparam logic [5:0] N_ADDR   = 6'h20;
  localparam int CLK_MHZ      = 250;
  localparam int STATUS_WRITE_COMMAND_TIME_NS = 4000;
  localparam int STATUS_WRITE_COMMAND_CYC     = STATUS_WRITE_COMMAND_TIME_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_BODY, ST_DOUT} fss_state_type;

  // Quad-mode dummy clocks for a dummy-count code.
  function automatic logic [3:0] fss_dummy_clk(input logic [1:0] code);
    case (code)
      2'h0:    fss_dummy_clk = 4'h6;
      2'h1:    fss_dummy_clk = 4'h4;
      2'h2:    fss_dummy_clk = 4'h8;
      default: fss_dummy_clk = 4'hA;
    endcase
  endfunction

endpackage

/* hw/fss_sync.sv */
// Two-flop synchroniser for pins that arrive from outside clk_sys.
`timescale 1ns/1ps
module fss_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ****************************************************************
  // Stages
  // ****************************************************************
  // Idle chip select rests high, so reset to ones keeps the frame logic quiet.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // fss_sync

/* hw/fss_timer.sv */
// Self-timed cycle counter for the status write cycle.
`timescale 1ns/1ps
module fss_timer #(
  parameter int CYC = 1000
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_q;

  // ****************************************************************
  // Countdown
  // ****************************************************************
  // A start while running is ignored; the caller never issues one.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (start && cnt_q == '0) begin
      cnt_q <= CW'(CYC);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = (cnt_q == CW'(1));

endmodule // fss_timer

/* hw/fss_status_regs.sv */
// Status and configuration registers of a serial flash, on the SPI pins.
// How it works
// R1: Bit 0 reads 1 while a status write, program or erase runs.
// R2: Bit 1 is the write latch; stored status writes, programs and erases need it set.
// R3: Nonzero protect bits 5:2 shield their area from program and erases.
// R4: Whole-array erase only runs with protect bits and boot lock all zero.
// R5: Protect bits change only while the write-protect pin is high.
// R6: Boot lock shields the top or bottom block or sector.
// R7: Permanent bit resets 0; once set it freezes itself, protects, OTP lock.
// R8: In OTP mode bits 7, 4, 3 become OTP lock, size, top/bottom.
// R9: Top/bottom select: 0 top, 1 bottom; set only in OTP mode.
// R10: Size switch: 1 sector, 0 block; defaults 0, set in OTP mode.
// R11: OTP lock set once by status write; then OTP sector is read-only.
// R12: Busy bit in the status byte equals the internal busy flag.
// R13: Config byte reads at any time and repeats while clocked.
// R14: Host should poll busy before new commands during internal cycles.
// R15: Dummy code bits 5:4, default 00: 3, 2, 4, 5 bytes.
// R16: Quad dummy clocks are 6, 4, 8, 10 for codes 00 to 11.
// R17: Drive bits 3:2, default 00 is 67 percent; 01 is full.
// R18: Config bits 7, 6, 1, 0 are reserved and read zero.
// R19: Write enable command sets the write latch.
// R20: Latch clears at reset and after status write, program, erase.
// R21: Volatile enable keeps the latch; next status write is volatile.
// R22: Status bytes shift out MSB first, one bit per serial clock.
`timescale 1ns/1ps
module fss_status_regs
  import fss_pkg::*;
#(
  parameter int STATUS_WRITE_COMMAND_CYCLES = STATUS_WRITE_COMMAND_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        spi_clk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_di,
  input  wire logic        wp_n,
  input  wire logic        otp_mode,
  input  wire logic        area_hit,
  input  wire logic        array_done,
  output logic             spi_do,
  output logic             spi_do_oe,
  output logic             array_start,
  output logic      [7:0]  array_cmd,
  output logic      [23:0] array_addr,
  output logic      [7:0]  status_byte,
  output logic      [7:0]  config_status_byte,
  output logic      [3:0]  read_dummy_clks,
  output logic      [1:0]  drive_code
);

  // ****************************************************************
  // Pin sampling and edge detection
  // ****************************************************************
  logic sclk_s, cs_n_s, di_s, wp_n_s;
  logic sclk_p_q, cs_p_q;
  logic rise, fall, f_start, f_end;

  fss_sync #(.W(4)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({spi_clk, spi_cs_n, spi_di, wp_n}),
    .q       ({sclk_s, cs_n_s, di_s, wp_n_s})
  );

  // Edges come from the synchronised copies only.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_p_q <= 1'b1;
      cs_p_q   <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      cs_p_q   <= cs_n_s;
    end
  end

  assign rise    = !cs_n_s && sclk_s && !sclk_p_q;
  assign fall    = !cs_n_s && !sclk_s && sclk_p_q;
  assign f_start = !cs_n_s && cs_p_q;
  assign f_end   = cs_n_s && !cs_p_q;

  // ****************************************************************
  // Frame capture
  // ****************************************************************
  fss_state_type state_q;
  logic [5:0]  nbit_q;
  logic [31:0] sh_q;
  logic [7:0]  cmd_q, dat_q;
  logic [23:0] addr_q;
  logic [7:0]  out_q;
  logic [2:0]  oidx_q;
  logic        do_q, oe_q;
  logic [31:0] sh_d;

  assign sh_d = {sh_q[30:0], di_s};

  // Bits are taken on rising serial clock edges; the count saturates.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || f_start) begin
      nbit_q <= '0;
      sh_q   <= '0;
    end else if (rise) begin
      sh_q <= sh_d;
      if (nbit_q != '1) begin
        nbit_q <= nbit_q + 1'b1;
      end
    end
  end

  // Command, data byte and address are latched at their bit counts.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_q  <= '0;
      dat_q  <= '0;
      addr_q <= '0;
    end else if (rise) begin
      if (nbit_q == N_CMD - 1'b1) begin
        cmd_q <= sh_d[7:0];
      end
      if (nbit_q == N_STATUS_WRITE_COMMAND - 1'b1) begin
        dat_q <= sh_d[7:0];
      end
      if (nbit_q == N_ADDR - 1'b1) begin
        addr_q <= sh_d[23:0];
      end
    end
  end

  // ****************************************************************
  // Protection state, status and config bytes
  // ****************************************************************
  logic [8:0] live_q, nv_q, pend_q;
  logic [7:0] cfg_q;
  logic       wel_q, vol_q, arr_busy_q, write_in_progress_flag;
  logic       t_busy, t_done, t_start;
  logic [3:0] bp;

  assign bp  = live_q[PV_BP_HI:PV_BP_LO];
  assign write_in_progress_flag = t_busy || arr_busy_q; // R1 R12

  // Status write image; OTP-mode bits only ever go from 0 to 1.
  function automatic logic [8:0] status_write_command_apply(input logic [8:0] cur,
                                            input logic [7:0] d,
                                            input logic otp,
                                            input logic wp_ok);
    logic [8:0] r;
    r = cur;
    if (otp) begin
      r[PV_TB]   = cur[PV_TB] | d[SB_TB]; // R9
      r[PV_SIZE] = cur[PV_SIZE] | d[SB_SIZE]; // R10
      if (!cur[PV_PPB]) begin
        r[PV_OTPL] = cur[PV_OTPL] | d[SB_OTPL]; // R11
      end
    end else begin
      r[PV_EBL] = d[SB_EBL];
      if (!cur[PV_PPB]) begin
        r[PV_PPB] = d[SB_PPB]; // R7
        if (wp_ok) begin
          r[PV_BP_HI:PV_BP_LO] = d[SB_BP_HI:SB_BP_LO]; // R5
        end
      end
    end
    return r;
  endfunction

  // OTP mode swaps the upper field meanings and hides reserved bits.
  always_comb begin
    if (otp_mode) begin
      status_byte = {live_q[PV_OTPL], 2'h0, live_q[PV_SIZE],
                     live_q[PV_TB], 1'h0, wel_q, write_in_progress_flag}; // R8
    end else begin
      status_byte = {live_q[PV_PPB], live_q[PV_EBL], bp, wel_q, write_in_progress_flag};
    end
  end

  assign config_status_byte = cfg_q & CB_WMASK; // R18
  assign drive_code         = cfg_q[CB_DRV_HI:CB_DRV_LO]; // R17
  assign read_dummy_clks    =
    fss_dummy_clk(cfg_q[CB_DUM_HI:CB_DUM_LO]); // R15 R16

  // ****************************************************************
  // Command execution at the end of a frame
  // ****************************************************************
  logic is_wr, is_ce, boot_hit, blocked, ce_ok, ex_ok;
  logic arr_ok, ce_go, status_write_command_ok, start_q;

  assign is_wr = (cmd_q == OP_PP) || (cmd_q == OP_QPP) ||
                 (cmd_q == OP_SE) || (cmd_q == OP_HBE) ||
                 (cmd_q == OP_BE);
  assign is_ce = (cmd_q == OP_CE1) || (cmd_q == OP_CE2);

  // Boot target is the top or bottom 64KB block or 4KB sector.
  always_comb begin
    if (live_q[PV_SIZE]) begin
      boot_hit = live_q[PV_TB] ? ~|addr_q[23:12] : &addr_q[23:12];
    end else begin
      boot_hit = live_q[PV_TB] ? ~|addr_q[23:16] : &addr_q[23:16];
    end
  end

  assign blocked = (|bp && area_hit) || // R3
                   (live_q[PV_EBL] && boot_hit) || // R6
                   (otp_mode && live_q[PV_OTPL]); // R11
  assign ce_ok   = (bp == '0) && !live_q[PV_EBL] &&
                   !(otp_mode && live_q[PV_OTPL]); // R4
  assign ex_ok   = f_end && !write_in_progress_flag && (state_q != ST_DOUT);
  assign arr_ok  = ex_ok && wel_q && is_wr && nbit_q >= N_ADDR &&
                   !blocked; // R2 R3
  assign ce_go   = ex_ok && wel_q && is_ce && nbit_q == N_CMD &&
                   ce_ok; // R4
  assign status_write_command_ok = ex_ok && cmd_q == OP_STATUS_WRITE_COMMAND && nbit_q == N_STATUS_WRITE_COMMAND &&
                   (wel_q || vol_q); // R2 R21
  assign t_start = status_write_command_ok && !vol_q;

  fss_timer #(.CYC(STATUS_WRITE_COMMAND_CYCLES)) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (t_start),
    .busy    (t_busy),
    .done    (t_done)
  );

  // Write latch: WRITE_ENABLE_COMMAND sets; a finished cycle or WRDI clears it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wel_q <= 1'b0; // R20
    end else if (ex_ok && cmd_q == OP_WRITE_ENABLE_COMMAND && nbit_q == N_CMD) begin
      wel_q <= 1'b1; // R19
    end else if (t_done || (arr_busy_q && array_done)) begin
      wel_q <= 1'b0; // R20
    end else if (ex_ok && cmd_q == OP_WRDI && nbit_q == N_CMD) begin
      wel_q <= 1'b0;
    end
  end

  // Volatile enable lasts only until the next status write or WRDI.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vol_q <= 1'b0;
    end else if (ex_ok && cmd_q == OP_VWREN && nbit_q == N_CMD) begin
      vol_q <= 1'b1; // R21
    end else if (status_write_command_ok ||
                 (ex_ok && cmd_q == OP_WRDI && nbit_q == N_CMD)) begin
      vol_q <= 1'b0;
    end
  end

  // Volatile writes land at once; stored writes wait for the cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      live_q <= PV_RST;
      nv_q   <= PV_RST;
      pend_q <= PV_RST;
    end else if (status_write_command_ok && vol_q) begin
      live_q <= status_write_command_apply(live_q, dat_q, otp_mode, wp_n_s); // R21
    end else if (t_start) begin
      pend_q <= status_write_command_apply(nv_q, dat_q, otp_mode, wp_n_s);
    end else if (t_done) begin
      nv_q   <= pend_q;
      live_q <= pend_q;
    end
  end

  // Config byte writes are volatile and need no latch.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_q <= CB_RST; // R15 R17
    end else if (ex_ok && cmd_q == OP_WRSR3 && nbit_q == N_STATUS_WRITE_COMMAND) begin
      cfg_q <= dat_q & CB_WMASK; // R18
    end
  end

  // Array operations hold busy until the datapath reports completion.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      arr_busy_q <= 1'b0;
      start_q    <= 1'b0;
      array_cmd  <= '0;
    end else begin
      start_q <= arr_ok || ce_go;
      if (arr_ok || ce_go) begin
        arr_busy_q <= 1'b1; // R1
        array_cmd  <= cmd_q;
      end else if (array_done) begin
        arr_busy_q <= 1'b0;
      end
    end
  end

  assign array_start = start_q;
  assign array_addr  = addr_q;

  // ****************************************************************
  // Serial output of the status bytes
  // ****************************************************************
  // The byte is refreshed each time it wraps, so polling sees WRITE_IN_PROGRESS_FLAG fall.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || f_end) begin
      state_q <= ST_IDLE;
      oe_q    <= 1'b0;
      do_q    <= 1'b0;
      oidx_q  <= '1;
      out_q   <= '0;
    end else if (f_start) begin
      state_q <= ST_CMD;
    end else if (state_q == ST_CMD && rise && nbit_q == N_CMD - 1'b1) begin
      if (sh_d[7:0] == OP_READ_STATUS_COMMAND) begin
        state_q <= ST_DOUT;
        out_q   <= status_byte; // R12
      end else if (sh_d[7:0] == OP_READ_STATUS3_COMMAND) begin
        state_q <= ST_DOUT;
        out_q   <= config_status_byte; // R13
      end else begin
        state_q <= ST_BODY;
      end
    end else if (state_q == ST_DOUT && fall) begin
      oe_q   <= 1'b1;
      do_q   <= out_q[oidx_q]; // R22
      oidx_q <= oidx_q - 1'b1;
      if (oidx_q == '0) begin
        out_q <= (cmd_q == OP_READ_STATUS_COMMAND) ? status_byte
                                    : config_status_byte; // R13
      end
    end
  end

  assign spi_do    = do_q;
  assign spi_do_oe = oe_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_start_busy: assert property (@(posedge clk_sys) // R1
    disable iff (!rst_n) array_start |-> write_in_progress_flag)
    else $error("array start without busy");
  chk_start_wel: assert property (@(posedge clk_sys) // R2
    disable iff (!rst_n) array_start |-> $past(wel_q, 2))
    else $error("array start without write latch");
  chk_ce_guard: assert property (@(posedge clk_sys) // R4
    disable iff (!rst_n) ce_go |-> bp == '0 && !live_q[PV_EBL])
    else $error("chip erase while protected");
  chk_ppb_freeze: assert property (@(posedge clk_sys) // R7
    disable iff (!rst_n) $past(live_q[PV_PPB]) |-> live_q[PV_PPB] &&
      $stable(live_q[PV_BP_HI:PV_OTPL]))
    else $error("permanent bits changed");
  chk_otp_once: assert property (@(posedge clk_sys) // R11
    disable iff (!rst_n) $past(live_q[PV_OTPL]) |-> live_q[PV_OTPL])
    else $error("OTP lock cleared");
  chk_wel_clear: assert property (@(posedge clk_sys) // R20
    disable iff (!rst_n) (arr_busy_q && array_done) || t_done |=> !wel_q)
    else $error("write latch not cleared");
  chk_write_enable_command_set: assert property (@(posedge clk_sys) // R19
    disable iff (!rst_n) ex_ok && cmd_q == OP_WRITE_ENABLE_COMMAND && nbit_q == N_CMD
      |=> wel_q ##1 wel_q)
    else $error("write enable not taken");
  chk_vwren_keep: assert property (@(posedge clk_sys) // R21
    disable iff (!rst_n) ex_ok && cmd_q == OP_VWREN && nbit_q == N_CMD
      |=> $stable(wel_q) && vol_q)
    else $error("volatile enable touched latch");
  chk_dummy_map: assert property (@(posedge clk_sys) // R16
    disable iff (!rst_n)
      cfg_q[CB_DUM_HI:CB_DUM_LO] == 2'h1 |-> read_dummy_clks == 4'h4)
    else $error("dummy clock map wrong");
  chk_status_write_command_busy: assert property (@(posedge clk_sys) // R1
    disable iff (!rst_n) t_start |=> write_in_progress_flag [*8])
    else $error("status write cycle not busy");

endmodule // fss_status_regs

/* tb/fss_host_model.sv */
// SPI host model that frames single-line commands for the status block.
`timescale 1ns/1ps
module fss_host_model (
  input  wire logic clk_sys,
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_di,
  input  wire logic spi_do
);
  // Half period of the 125 ns serial clock.
  localparam realtime HALF = 62.5;

  // Idle: deselected, clock parked low between frames.
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_di   = 1'b1;
  end

  // One frame: n bits from the top of tx, MSB first; the last 8 bits
  // sampled on rising edges come back in rx. The start offset keeps
  // every serial edge away from a clk_sys rising edge.
  task automatic frame(input int n, input logic [39:0] tx,
                       output logic [7:0] rx);
    @(negedge clk_sys);
    #0.3;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_di = tx[39-i];
      #HALF;
      spi_clk = 1'b1;
      rx = {rx[6:0], spi_do};
      #HALF;
      spi_clk = 1'b0;
    end
    #HALF;
    spi_cs_n = 1'b1;
    // The released data line must not keep its last value.
    spi_di = ~spi_di;
    #100;
    @(negedge clk_sys);
  endtask
endmodule // fss_host_model

/* tb/tb_fss_status_regs.sv */
// Self-checking bench for the flash status register block.
`timescale 1ns/1ps
module tb_fss_status_regs;
  import fss_pkg::*;
  localparam int WCYC  = 1200;
  localparam int LIMIT = 80000;
  localparam logic [3:0] DCLK [4] = '{4'h6, 4'h4, 4'h8, 4'hA};
  logic        clk_sys, rst_n, wp_n, otp_mode, area_hit, array_done;
  logic        spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe, array_start;
  logic [7:0]  array_cmd, status_byte, config_status_byte, rx, cfg;
  logic [23:0] array_addr;
  logic [3:0]  read_dummy_clks;
  logic [1:0]  drive_code;
  int          n_errors, checks_done, n_starts, cycles, n_oe, oe_mark;

  fss_status_regs #(.STATUS_WRITE_COMMAND_CYCLES(WCYC)) fss_status_regs_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_di(spi_di), .wp_n(wp_n),
    .otp_mode(otp_mode), .area_hit(area_hit), .array_done(array_done),
    .spi_do(spi_do), .spi_do_oe(spi_do_oe), .array_start(array_start),
    .array_cmd(array_cmd), .array_addr(array_addr),
    .status_byte(status_byte), .config_status_byte(config_status_byte),
    .read_dummy_clks(read_dummy_clks), .drive_code(drive_code));

  fss_host_model host_i (
    .clk_sys(clk_sys), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_di(spi_di), .spi_do(spi_do));

  // ****************************************************************
  // Clock, watchdog and start counter
  // ****************************************************************
  // A 4 ns system clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Counts array start pulses and cuts a hang short.
  always @(posedge clk_sys) begin
    cycles++;
    if (array_start === 1'b1) n_starts++;
    if (spi_do_oe === 1'b1) n_oe++;
    if (cycles == LIMIT) begin
      n_errors++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compares a byte result.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Compares an address result.
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic cmd8(input logic [7:0] op);
    host_i.frame(8, {op, 32'h0}, rx);
  endtask

  task automatic read_status_command(input logic [7:0] exp);
    host_i.frame(16, {OP_READ_STATUS_COMMAND, 32'h0}, rx);
    chk8(rx, exp);
  endtask

  // Polls the busy bit over the link with a bounded number of reads.
  task automatic poll;
    for (int i = 0; i < 40; i++) begin
      host_i.frame(16, {OP_READ_STATUS_COMMAND, 32'h0}, rx);
      if (rx[0] === 1'b0) break;
    end
    chk8({7'h0, rx[0]}, 8'h00);
  endtask

  task automatic status_write_command(input logic [7:0] d);
    cmd8(OP_WRITE_ENABLE_COMMAND);
    host_i.frame(16, {OP_STATUS_WRITE_COMMAND, d, 24'h0}, rx);
    poll();
  endtask

  // Sends a program or erase and checks whether it started; finishes it if so.
  task automatic erase(input logic [7:0] op, input logic [23:0] a,
                       input int exp);
    int s;
    logic ce;
    s = n_starts;
    ce = (op == OP_CE1) || (op == OP_CE2);
    cmd8(OP_WRITE_ENABLE_COMMAND);
    host_i.frame(ce ? 8 : 32, {op, a, 8'h0}, rx);
    repeat (10) @(negedge clk_sys);
    chk8(8'(n_starts - s), 8'(exp));
    if (exp == 1) begin
      chk8(array_cmd, op);
      if (!ce) chk24(array_addr, a);
      chk8({7'h0, status_byte[0]}, 8'h01);
      array_done = 1'b1;
      @(negedge clk_sys);
      array_done = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Reset is held two cycles; every flop, pin flops too, loads on the first rising clk_sys edge.
  initial begin
    rst_n = 1'b0; wp_n = 1'b1; otp_mode = 1'b0;
    area_hit = 1'b0; array_done = 1'b0;
    n_errors = 0; checks_done = 0; n_starts = 0; cycles = 0;
    n_oe = 0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk8(status_byte, 8'h00);
    chk8(config_status_byte, 8'h00);
    chk8({4'h0, read_dummy_clks}, 8'h06);
    chk8({6'h0, drive_code}, 8'h00);
    chk8({7'h0, spi_do_oe}, 8'h00);
    read_status_command(8'h00);
    host_i.frame(16, {OP_STATUS_WRITE_COMMAND, 8'h3C, 24'h0}, rx);
    read_status_command(8'h00);
    cmd8(OP_WRITE_ENABLE_COMMAND);
    read_status_command(8'h02);
    cmd8(OP_WRDI);
    read_status_command(8'h00);
    cmd8(OP_WRITE_ENABLE_COMMAND);
    // OTP layout: top/bottom and size switch set, busy seen meanwhile.
    otp_mode = 1'b1;
    host_i.frame(16, {OP_STATUS_WRITE_COMMAND, 8'h18, 24'h0}, rx);
    host_i.frame(16, {OP_READ_STATUS_COMMAND, 32'h0}, rx);
    chk8(rx & 8'h01, 8'h01);
    chk8({7'h0, status_byte[0]}, 8'h01);
    poll();
    chk8(status_byte & 8'h9B, 8'h18);
    otp_mode = 1'b0;
    // Boot lock on the bottom sector.
    status_write_command(8'h40);
    read_status_command(8'h40);
    erase(OP_HBE, 24'h000000, 0);
    erase(OP_SE, 24'h800000, 1);
    read_status_command(8'h40);
    erase(OP_CE1, 24'h0, 0);
    status_write_command(8'h04);
    read_status_command(8'h04);
    erase(OP_CE2, 24'h0, 0);
    area_hit = 1'b1;
    erase(OP_PP, 24'h800000, 0);
    area_hit = 1'b0;
    wp_n = 1'b0;
    status_write_command(8'h00);
    chk8(status_byte & 8'h3C, 8'h04);
    wp_n = 1'b1;
    status_write_command(8'h00);
    read_status_command(8'h00);
    erase(OP_CE1, 24'h0, 1);
    read_status_command(8'h00);
    cmd8(OP_VWREN);
    read_status_command(8'h00);
    host_i.frame(16, {OP_STATUS_WRITE_COMMAND, 8'h10, 24'h0}, rx);
    read_status_command(8'h10);
    // OTP lock set once; in OTP mode it then refuses every program.
    otp_mode = 1'b1;
    status_write_command(8'h80);
    read_status_command(8'h98);
    erase(OP_QPP, 24'h800000, 0);
    otp_mode = 1'b0;
    status_write_command(8'h84);
    read_status_command(8'h84);
    status_write_command(8'h00);
    chk8(status_byte & 8'hFC, 8'h84);
    // Every dummy code with a drive code, read back three times over.
    for (int c = 0; c < 4; c++) begin
      cfg = {2'h3, c[1:0], c[1:0] ^ 2'h1, 2'h3};
      host_i.frame(16, {OP_WRSR3, cfg, 24'h0}, rx);
      oe_mark = n_oe;
      host_i.frame(32, {OP_READ_STATUS3_COMMAND, 32'h0}, rx);
      chk8(rx, cfg & 8'h3C);
      chk8(8'(n_oe > oe_mark), 8'h01);
      chk8({7'h0, spi_do_oe}, 8'h00);
      chk8({4'h0, read_dummy_clks}, {4'h0, DCLK[c]});
      chk8({6'h0, drive_code}, {6'h0, c[1:0] ^ 2'h1});
    end
    wrap_up();
  end
endmodule // tb_fss_status_regs
